// ### design/sfcu_flag_unit.sv
// status flag control unit: flag instructions, flag transfers and index stepping
//
// What this block does
// - carry flag: set, clear and invert
// - direction flag: set and clear
// - string step: increment if direction clear, else decrement
// - flags-to-high-byte: sign,zero,aux,parity,carry to 7,6,4,2,0
// - high byte bits 5,3,1 get the fixed fill 0,0,1
// - high-byte-to-flags loads 7,6,4,2,0 into five flags
// - word push writes low sixteen bits only
// - doubleword push clears resume and virtual bits
// - word pop always updates bits 11,10,8,7,6,4,2,0
// - pop updates privilege field only at level zero
// - pop updates interrupt enable if io level >= current
// - doubleword pop also updates bits 18 and 21
// - interrupt enable: set and clear operations
// - maskable interrupt serviced only while enable is one
// - enable operations permitted by mode and privilege
`timescale 1ns/1ps
module sfcu_flag_unit
  import sfcu_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_op_valid,
  input  wire logic [3:0]  i_op_code,
  input  wire logic [1:0]  i_op_size,
  input  wire logic [31:0] i_pop_data,
  input  wire logic        i_maskable_irq_pin,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic      [31:0] o_psw,
  output logic      [7:0]  o_high_accum_byte,
  output logic      [31:0] o_source_index_reg,
  output logic      [31:0] o_dest_index_reg,
  output logic             o_push_valid,
  output logic             o_push_dword,
  output logic      [31:0] o_push_data,
  output logic             o_prot_fault,
  output logic             o_irq_take
);

  sfcu_req_t   req;
  sfcu_bus_t   bus;
  sfcu_state_t st_r;
  sfcu_state_t st_nxt;

  // how the unit is organised
  //   all state lives in one packed struct, st_r, registered on every edge
  //   one combinational process builds st_nxt from st_r and the inputs
  //   nothing else holds state, so reset has a single place to act
  //
  // software port
  //   a write lands on the next edge and is seen by an op on that same edge
  //   a read shows the value held before any update of its own cycle
  //   read data stand for exactly one cycle and return to zero after it
  //   unmapped offsets ignore writes and read back as zero
  //   the port never stalls; strobes may come on back to back cycles
  //   a write to the status word always leaves bit 1 set
  //   a write of any value to the fault count clears it
  //
  // instruction port
  //   one op per cycle; valid may stay high for a run of ops
  //   codes that are not listed fall through and change nothing
  //   the op acts on the state after any same-cycle software write
  //   the result is visible on the outputs right after the edge that takes the op
  //
  // single flag ops
  //   carry and direction ops touch only their own bit
  //   the invert op reads the carry after a same-cycle write
  //   nothing here changes the index registers or the high byte
  //
  // high byte transfers
  //   the copy out keeps the status word as it was
  //   the three spare bits of the high byte get a fixed fill pattern
  //   a fixed fill keeps runs repeatable; software must not rely on it
  //   the copy in writes five flags and leaves the rest of the word
  //
  // push path
  //   a push raises the valid pulse for one cycle only
  //   the size flag and data hold their last value between pushes
  //   a word push clears the upper half of the data
  //   a doubleword push hides the resume and virtual-mode bits
  //   the stack itself lives outside; the unit only offers the word
  //
  // pop path
  //   the popped value arrives with the op and is used that cycle
  //   a fixed mask of arithmetic and control bits always follows it
  //   the io privilege field follows only at the top privilege level
  //   the enable flag follows only when io level is at or above
  //   the current level, judged on the io level before the pop
  //   using the old level avoids a loop through the freshly popped field
  //   a doubleword pop also lets the alignment and query bits follow
  //   bits outside the final mask keep their value, bit 1 included
  //
  // interrupt enable ops
  //   real mode always allows them
  //   protected mode allows them when io level is at or above current
  //   virtual mode allows them only at the highest io level
  //   a refused op keeps the flag, pulses the fault output for one cycle
  //   and counts one in the fault counter, which saturates never and wraps
  //   the fault output is only a marker; raising the trap is done elsewhere
  //
  // string step
  //   one step moves both index registers by the element size
  //   the direction flag chooses increment when clear, decrement when set
  //   an unused size code steps by one byte, the same as a byte element
  //   the indices wrap modulo two to the thirty-two with no warning
  //
  // interrupt gate
  //   the request pin passes straight through while the enable is set
  //   it is combinational so a request is never delayed by this unit
  //   the caller must treat the pin as synchronous to the clock
  //
  // reset
  //   reset is asynchronous and active high
  //   the status word comes out of reset with only bit 1 set
  //   every other field, pulse and counter comes out of reset at zero
  //
  // hazards a user must know
  //   a software write and an op on one edge both apply, write first
  //   a software read on that edge still shows the older value
  //   a clear of the fault count beside a refused op leaves it at one
  //   the unit keeps no history of pops; the stack holds that
  //
  // widths
  //   status word, indices and push data are thirty-two bits
  //   the high byte is eight bits, the fault count sixteen
  //   the privilege field of the control register is two bits
  //   all offsets and masks come from the shared package
  //
  // verification hooks
  //   every output that matters is registered and easy to sample
  //   the only combinational output is the interrupt gate
  //   pulses are one cycle long, so monitors look once per edge

  // io privilege numerically at or above the current privilege
  function automatic logic io_privilege_level_ge_cpl(input logic [31:0] psw, input logic [1:0] priv);
    io_privilege_level_ge_cpl = psw[IOPRIV_HI:IOPRIV_LO] >= priv;
  endfunction

  // permission of the interrupt enable operations by operating mode
  function automatic logic ie_op_allowed(input logic [31:0] psw, input logic [1:0] priv, input logic prot);
    logic ok;
    ok = 1'b1;
    if (prot && psw[V86_BIT]) begin
      ok = (psw[IOPRIV_HI:IOPRIV_LO] == IOPRIV_V86);
    end else if (prot) begin
      ok = io_privilege_level_ge_cpl(psw, priv);
    end
    ie_op_allowed = ok;
  endfunction

  // stride of one string element
  function automatic logic [31:0] step_size(input logic [1:0] size);
    logic [31:0] s;
    s = 32'h00000001;
    unique case (size)
      2'h1:    s = 32'h00000002;
      2'h2:    s = 32'h00000004;
      default: s = 32'h00000001;
    endcase
    step_size = s;
  endfunction

  // gather ports into carriers
  assign req = '{valid: i_op_valid, code: sfcu_op_t'(i_op_code), size: i_op_size, pop_data: i_pop_data};
  assign bus = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

  // next state: software writes first, then the instruction acts on the result
  always_comb begin
    logic [31:0] pmask;
    logic [31:0] stride;
    logic        ie_ok;
    pmask  = POP_BASE_MASK;
    stride = 32'h00000000;
    ie_ok  = 1'b0;
    st_nxt = st_r;
    st_nxt.push.valid = 1'b0;
    st_nxt.fault      = 1'b0;
    st_nxt.rdata      = 32'h00000000;

    // software port writes
    if (bus.wr) begin
      unique case (bus.addr)
        OFS_PSW:  st_nxt.psw = bus.wdata | PSW_RESET;
        OFS_CTRL: begin
          st_nxt.cur_priv = bus.wdata[CTRL_PRIV_LO +: 2];
          st_nxt.prot = bus.wdata[CTRL_PROT];
        end
        OFS_SRC:   st_nxt.src_idx   = bus.wdata;
        OFS_DST:   st_nxt.dst_idx   = bus.wdata;
        OFS_HACC:  st_nxt.hacc      = bus.wdata[7:0];
        OFS_FAULT: st_nxt.fault_cnt = 16'h0000;
        default: ;
      endcase
    end

    // instruction execution
    if (req.valid) begin
      unique case (req.code)
        OP_SET_CARRY: st_nxt.psw[CARRY_BIT] = 1'b1;
        OP_CLR_CARRY: st_nxt.psw[CARRY_BIT] = 1'b0;
        OP_INV_CARRY: st_nxt.psw[CARRY_BIT] = ~st_nxt.psw[CARRY_BIT];
        OP_SET_DIR:   st_nxt.psw[DIR_BIT] = 1'b1;
        OP_CLR_DIR:   st_nxt.psw[DIR_BIT] = 1'b0;
        OP_F_TO_HB: begin
          // status word is left as it is
          st_nxt.hacc = HB_FILL;
          st_nxt.hacc[7] = st_nxt.psw[SIGN_BIT];
          st_nxt.hacc[6] = st_nxt.psw[ZERO_BIT];
          st_nxt.hacc[4] = st_nxt.psw[AUX_BIT];
          st_nxt.hacc[2] = st_nxt.psw[PARITY_BIT];
          st_nxt.hacc[0] = st_nxt.psw[CARRY_BIT];
        end
        OP_HB_TO_F: begin
          st_nxt.psw[SIGN_BIT]   = st_nxt.hacc[7];
          st_nxt.psw[ZERO_BIT]   = st_nxt.hacc[6];
          st_nxt.psw[AUX_BIT]    = st_nxt.hacc[4];
          st_nxt.psw[PARITY_BIT] = st_nxt.hacc[2];
          st_nxt.psw[CARRY_BIT]  = st_nxt.hacc[0];
        end
        OP_PUSH_W: begin
          st_nxt.push.valid = 1'b1;
          st_nxt.push.dword = 1'b0;
          st_nxt.push.data  = {16'h0000, st_nxt.psw[15:0]};
        end
        OP_PUSH_DW: begin
          st_nxt.push.valid = 1'b1;
          st_nxt.push.dword = 1'b1;
          st_nxt.push.data  = st_nxt.psw & ~PUSH_DW_CLEAR;
        end
        OP_POP_W, OP_POP_DW: begin
          pmask = POP_BASE_MASK;
          if (st_nxt.cur_priv == PRIV_TOP) begin
            pmask = pmask | POP_IOPRIV_MASK;
          end
          if (io_privilege_level_ge_cpl(st_nxt.psw, st_nxt.cur_priv)) begin
            pmask = pmask | POP_IF_MASK;
          end
          if (req.code == OP_POP_DW) begin
            pmask = pmask | POP_DWORD_MASK;
          end
          st_nxt.psw = (st_nxt.psw & ~pmask) | (req.pop_data & pmask);
        end
        OP_SET_IE, OP_CLR_IE: begin
          ie_ok = ie_op_allowed(st_nxt.psw, st_nxt.cur_priv, st_nxt.prot);
          if (ie_ok) begin
            st_nxt.psw[IF_BIT] = (req.code == OP_SET_IE);
          end else begin
            st_nxt.fault = 1'b1;
            st_nxt.fault_cnt = st_nxt.fault_cnt + 16'h0001;
          end
        end
        OP_STR_STEP: begin
          stride = step_size(req.size);
          if (st_nxt.psw[DIR_BIT]) begin
            st_nxt.src_idx = st_nxt.src_idx - stride;
            st_nxt.dst_idx = st_nxt.dst_idx - stride;
          end else begin
            st_nxt.src_idx = st_nxt.src_idx + stride;
            st_nxt.dst_idx = st_nxt.dst_idx + stride;
          end
        end
        default: ;
      endcase
    end

    // software port reads show the state before this cycle's updates
    if (bus.rd) begin
      unique case (bus.addr)
        OFS_PSW:   st_nxt.rdata = st_r.psw;
        OFS_CTRL:  st_nxt.rdata = {29'h00000000, st_r.prot, st_r.cur_priv};
        OFS_SRC:   st_nxt.rdata = st_r.src_idx;
        OFS_DST:   st_nxt.rdata = st_r.dst_idx;
        OFS_HACC:  st_nxt.rdata = {24'h000000, st_r.hacc};
        OFS_FAULT: st_nxt.rdata = {16'h0000, st_r.fault_cnt};
        default:   st_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  // state register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r           <= '0;
      st_r.psw       <= PSW_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs from the state register
  assign o_rdata            = st_r.rdata;
  assign o_psw              = st_r.psw;
  assign o_high_accum_byte  = st_r.hacc;
  assign o_source_index_reg = st_r.src_idx;
  assign o_dest_index_reg   = st_r.dst_idx;
  assign o_push_valid       = st_r.push.valid;
  assign o_push_dword       = st_r.push.dword;
  assign o_push_data        = st_r.push.data;
  assign o_prot_fault       = st_r.fault;

  // interrupt request passes only while the enable flag is set
  assign o_irq_take = i_maskable_irq_pin & st_r.psw[IF_BIT];

endmodule

// ### include/sfcu_pkg.sv
// shared constants and types of the status flag control unit
package sfcu_pkg;

  // processor_status_word bit positions
  localparam int unsigned CARRY_BIT  = 0;
  localparam int unsigned PARITY_BIT = 2;
  localparam int unsigned AUX_BIT    = 4;
  localparam int unsigned ZERO_BIT   = 6;
  localparam int unsigned SIGN_BIT   = 7;
  localparam int unsigned TF_BIT     = 8;
  localparam int unsigned IF_BIT     = 9;
  localparam int unsigned DIR_BIT    = 10;
  localparam int unsigned OF_BIT     = 11;
  localparam int unsigned IOPRIV_LO  = 12;
  localparam int unsigned IOPRIV_HI  = 13;
  localparam int unsigned RESUME_BIT = 16;
  localparam int unsigned V86_BIT    = 17;
  localparam int unsigned ALIGN_BIT  = 18;
  localparam int unsigned QUERY_BIT  = 21;

  // masks of the word pop, the privileged fields and the doubleword extras
  localparam logic [31:0] POP_BASE_MASK  = 32'h00000dd5;
  localparam logic [31:0] POP_IOPRIV_MASK = 32'h00003000;
  localparam logic [31:0] POP_IF_MASK    = 32'h00000200;
  localparam logic [31:0] POP_DWORD_MASK = 32'h00240000;
  localparam logic [31:0] PUSH_DW_CLEAR  = 32'h00030000;
  localparam logic [31:0] PSW_RESET      = 32'h00000002;
  localparam logic [7:0]  HB_FILL        = 8'h02;   // value driven on the undefined bits 5, 3, 1

  // register offsets of the plain software port
  localparam logic [7:0] OFS_PSW    = 8'h00;
  localparam logic [7:0] OFS_CTRL   = 8'h04;
  localparam logic [7:0] OFS_SRC    = 8'h08;
  localparam logic [7:0] OFS_DST    = 8'h0c;
  localparam logic [7:0] OFS_HACC   = 8'h10;
  localparam logic [7:0] OFS_FAULT  = 8'h14;

  // control register fields
  localparam int unsigned CTRL_PRIV_LO = 0;
  localparam int unsigned CTRL_PROT    = 2;
  localparam logic [1:0]  PRIV_TOP     = 2'h0;
  localparam logic [1:0]  IOPRIV_V86   = 2'h3;

  // operations of the instruction stream
  typedef enum logic [3:0] {
    OP_NONE      = 4'h0,
    OP_SET_CARRY = 4'h1,
    OP_CLR_CARRY = 4'h2,
    OP_INV_CARRY = 4'h3,
    OP_SET_DIR   = 4'h4,
    OP_CLR_DIR   = 4'h5,
    OP_F_TO_HB   = 4'h6,
    OP_HB_TO_F   = 4'h7,
    OP_PUSH_W    = 4'h8,
    OP_PUSH_DW   = 4'h9,
    OP_POP_W     = 4'ha,
    OP_POP_DW    = 4'hb,
    OP_SET_IE    = 4'hc,
    OP_CLR_IE    = 4'hd,
    OP_STR_STEP  = 4'he
  } sfcu_op_t;

  // one instruction request
  typedef struct packed {
    logic        valid;
    sfcu_op_t    code;
    logic [1:0]  size;      // string element: 0 byte, 1 word, 2 doubleword
    logic [31:0] pop_data;  // value read from the memory stack for a pop
  } sfcu_req_t;

  // one write toward the memory stack
  typedef struct packed {
    logic        valid;
    logic        dword;
    logic [31:0] data;
  } sfcu_push_t;

  // software port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } sfcu_bus_t;

  // whole state of the unit
  typedef struct packed {
    logic [31:0] psw;
    logic [31:0] src_idx;
    logic [31:0] dst_idx;
    logic [7:0]  hacc;
    logic [1:0]  cur_priv;
    logic        prot;
    logic [15:0] fault_cnt;
    logic [31:0] rdata;
    sfcu_push_t  push;
    logic        fault;
  } sfcu_state_t;

endpackage

// ### dv/sfcu_sva.sv
// port assertions of the status flag control unit
`timescale 1ns/1ps
module sfcu_sva
  import sfcu_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_op_valid,
  input wire logic [3:0]  i_op_code,
  input wire logic [31:0] i_pop_data,
  input wire logic        i_wr,
  input wire logic        i_maskable_irq_pin,
  input wire logic [31:0] o_psw,
  input wire logic [7:0]  o_high_accum_byte,
  input wire logic        o_push_valid,
  input wire logic        o_push_dword,
  input wire logic [31:0] o_push_data,
  input wire logic        o_prot_fault,
  input wire logic        o_irq_take
);
  localparam logic [31:0] KEEP = ~(POP_BASE_MASK | POP_IOPRIV_MASK | POP_IF_MASK | POP_DWORD_MASK);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // an instruction taken with no software write on the same edge
  sequence s_op(logic [3:0] c);
    i_op_valid && !i_wr && i_op_code == c;
  endsequence
  sequence s_pop;
    i_op_valid && !i_wr && i_op_code[3:1] == 3'h5;
  endsequence
  a_set_carry: assert property (s_op(4'h1) |=> o_psw == ($past(o_psw) | 32'h1))
    else $error("carry set wrong");
  a_clear_carry: assert property (s_op(4'h2) |=> o_psw == ($past(o_psw) & ~32'h1))
    else $error("carry clear wrong");
  a_invert_carry: assert property (s_op(4'h3) |=> o_psw == ($past(o_psw) ^ 32'h1))
    else $error("carry invert wrong");
  a_dir_flag: assert property (i_op_valid && !i_wr && i_op_code[3:1] == 3'h2 |=> o_psw[10] != $past(i_op_code[0]))
    else $error("direction flag wrong");
  a_flags_to_hb: assert property (s_op(4'h6) |=> (o_high_accum_byte & 8'hd5) == ($past(o_psw[7:0]) & 8'hd5) && $stable(o_psw))
    else $error("flags to high byte wrong");
  a_hb_to_flags: assert property (s_op(4'h7) |=> (o_psw[7:0] & 8'hd5) == ($past(o_high_accum_byte) & 8'hd5))
    else $error("high byte to flags wrong");
  a_push_word: assert property (s_op(4'h8) |=> o_push_valid && !o_push_dword && o_push_data == {16'h0, $past(o_psw[15:0])})
    else $error("word push wrong");
  a_push_dword: assert property (s_op(4'h9) |=> o_push_valid && o_push_dword && o_push_data == ($past(o_psw) & ~PUSH_DW_CLEAR))
    else $error("doubleword push wrong");
  a_pop_base: assert property (s_pop |=> ((o_psw ^ $past(i_pop_data)) & POP_BASE_MASK) == 32'h0)
    else $error("pop base bits wrong");
  a_pop_keep: assert property (s_pop |=> ((o_psw ^ $past(o_psw)) & KEEP) == 32'h0)
    else $error("pop touched kept bits");
  a_irq_mask: assert property (o_irq_take == (i_maskable_irq_pin && o_psw[9]))
    else $error("interrupt mask wrong");
  a_fault_keep: assert property (o_prot_fault && $past(!i_wr) |-> o_psw[9] == $past(o_psw[9]))
    else $error("refused op changed enable");
endmodule

bind sfcu_flag_unit sfcu_sva u_sva (.*);

// ### dv/sfcu_stack_model.sv
// behavioural memory stack behind the push and pop paths
`timescale 1ns/1ps
module sfcu_stack_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_push_valid,
  input  wire logic [31:0] i_push_data,
  input  wire logic        i_pop,
  output logic      [31:0] o_top
);
  logic [31:0] mem [16];
  int          sp   = 0;
  logic [31:0] junk = 32'h5a5a5a5a;
  // an empty stack shows a pattern that flips every cycle
  assign o_top = (sp > 0) ? mem[sp-1] : junk;
  // store pushes, drop the top on a pop
  always @(posedge i_ref_clk) begin
    junk <= ~junk;
    if (i_push_valid && sp < 16) begin
      mem[sp] <= i_push_data;
      sp      <= sp + 1;
    end else if (i_pop && sp > 0) begin
      sp <= sp - 1;
    end
  end
endmodule

// ### dv/sfcu_flag_unit_tb.sv
// self-checking bench of the status flag control unit
`timescale 1ns/1ps
module sfcu_flag_unit_tb;
  import sfcu_pkg::*;
  logic        i_ref_clk = 0, i_rst = 1, i_op_valid = 0, i_wr = 0, i_rd = 0, i_maskable_irq_pin = 0;
  logic [3:0]  i_op_code = 0;
  logic [1:0]  i_op_size = 0, cur_priv;
  logic [7:0]  i_addr = 0, h;
  logic [31:0] i_pop_data = 0, i_wdata = 0, o_rdata, o_psw, o_source_index_reg, o_dest_index_reg;
  logic [31:0] o_push_data, top, m, r, mk, src = 0, dst = 0, x = 32'd74;
  logic [7:0]  o_high_accum_byte;
  logic        o_push_valid, o_push_dword, o_prot_fault, o_irq_take, pop = 0, rd_seen = 0, prot;
  logic [31:0] exp_q [$];
  int          fail_count = 0, samples_checked = 0, fc = 0, d;

  sfcu_flag_unit u_sfcu_flag_unit (.*);
  sfcu_stack_model u_sfcu_stack_model (.i_ref_clk, .i_push_valid(o_push_valid), .i_push_data(o_push_data),
                                       .i_pop(pop), .o_top(top));

  // clock and hang guard
  initial forever #5 i_ref_clk = ~i_ref_clk;
  initial begin
    #50000;
    fail_count++;
    finish_test;
  end

  function automatic logic [31:0] xs();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      fail_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // one register write or read; a read notes its expected answer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge i_ref_clk);
    i_wr    <= w;
    i_rd    <= !w;
    i_addr  <= a;
    i_wdata <= v;
    if (!w) exp_q.push_back(v);
    @(posedge i_ref_clk);
    i_wr <= 0;
    i_rd <= 0;
  endtask

  // one instruction, pops take the stack top
  task automatic op(input logic [3:0] c, input logic [1:0] s);
    @(posedge i_ref_clk);
    i_op_valid <= 1;
    i_op_code  <= c;
    i_op_size  <= s;
    i_pop_data <= top;
    pop        <= c[3:1] == 3'h5;
    @(posedge i_ref_clk);
    i_op_valid <= 0;
    pop        <= 0;
  endtask

  // compare read answers and stack writes with the oldest note
  always @(posedge i_ref_clk) begin
    if (rd_seen) chk(o_rdata, exp_q.pop_front());
    if (o_push_valid) chk(o_push_data, exp_q.pop_front());
    rd_seen <= i_rd;
  end

  task automatic finish_test;
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // every operation in turn over random flags, privilege and mode
  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 0;
    bus(0, OFS_PSW, PSW_RESET);
    bus(0, 8'h40, 0);
    for (int i = 0; i < 60; i++) begin
      r = xs();
      m = r | 32'h2;
      bus(1, OFS_PSW, r);
      r = xs();
      cur_priv = r[1:0];
      prot = r[2];
      h    = r[15:8];
      i_maskable_irq_pin <= r[20];
      bus(1, OFS_CTRL, {29'h0, r[2:0]});
      bus(1, OFS_HACC, {24'h0, h});
      op(4'(i % 15), r[17:16]);
      case (i % 15)
        1: m[0] = 1;
        2: m[0] = 0;
        3: m[0] = !m[0];
        4: m[10] = 1;
        5: m[10] = 0;
        6: h = m[7:0] & 8'hd5 | HB_FILL;
        7: m[7:0] = m[7:0] & 8'h2a | h & 8'hd5;
        8: exp_q.push_back({16'h0, m[15:0]});
        9: exp_q.push_back(m & ~PUSH_DW_CLEAR);
        10, 11: begin
          mk = POP_BASE_MASK | (cur_priv == 0 ? POP_IOPRIV_MASK : 0) | (m[13:12] >= cur_priv ? POP_IF_MASK : 0);
          mk = mk | ((i % 15 == 11) ? POP_DWORD_MASK : 0);
          m  = m & ~mk | i_pop_data & mk;
        end
        12, 13: begin
          if (!prot || (m[17] ? m[13:12] == 2'h3 : m[13:12] >= cur_priv)) m[9] = (i % 15 == 12);
          else fc++;
        end
        14: begin
          d   = (r[17:16] == 1) ? 2 : (r[17:16] == 2) ? 4 : 1;
          src = m[10] ? src - d : src + d;
          dst = m[10] ? dst - d : dst + d;
        end
        default: ;
      endcase
      bus(0, OFS_PSW, m);
      bus(0, OFS_HACC, {24'h0, h});
      bus(0, OFS_SRC, src);
      bus(0, OFS_DST, dst);
      bus(0, OFS_FAULT, fc & 32'hffff);
    end
    repeat (3) @(posedge i_ref_clk);
    finish_test;
  end
endmodule
